// >>> ises_regs.sv
// Status event flag registers: standard, operation and measurement event sets
// Overview of operation
// - Three independent register sets; questionable set lives elsewhere, summaries kept separate.
// - Operation-complete bit 0 sets only on completion query with nothing pending.
// - Query-error bit 2 sets when host reads an empty output queue.
// - Backed-memory error bit 3 sets on unresumable scan or lost stored data.
// - Execution-error bit 4 sets when a command fails while executing.
// - Device-dependent errors also set bit 3, shared with backed-memory error.
// - User-request bit 6 sets when the front-panel local key is pressed.
// - Power-on bit 7 sets after power cycle, holds until register read or clear-status.
// - Operation bit 4 sets while a measurement is in progress.
// - Operation bit 5 sets while the trigger layer awaits a trigger.
// - Operation bit 8 sets when filter settled or filter disabled.
// - Operation bit 10 sets while the instrument is idle.
// - Measurement bit 0 sets when a reading exceeds the range.
// - Bits 1 to 4 set on low/high limit one and two reached.
// - Measurement bit 5 sets each time a reading is processed.
// - Bit 6 sets when stored count reaches the programmed notify count.
// - Bit 7 sets when the buffer holds at least two readings.
// - Bit 8 sets at half full, bit 9 at full.
// - Bits 12 and 13 set at quarter and three-quarter fill.
// - Bit 10 sets when a full buffer wraps over stored readings.
// - Bit 11 sets when a reading passes the hardware limit.
// - Bit 14 sets whenever any other limit condition is reached.
// - Every flag latches at one until its register is cleared.
// - Reading a register clears all its bits except those set again in the same cycle.
// - Summary output is OR of flags ANDed with enables.
// - Enables reset to zero at power-up and preset; clear-status leaves them.
`include "ises_cfg.svh"

module ises_regs (
    input  wire logic                      clock_in,
    input  wire logic                      nrst_in,
    // Instrument conditions, synchronous one-cycle events or levels
    input  wire logic                      opc_query_in,
    input  wire logic                      ops_pending_in,
    input  wire logic                      empty_queue_read_in,
    input  wire logic                      err_scan_resume_in,
    input  wire logic                      err_data_lost_in,
    input  wire logic                      err_setup_mismatch_in,
    input  wire logic                      err_module_comm_in,
    input  wire logic                      err_module_unsup_in,
    input  wire logic                      exec_error_in,
    input  wire logic                      local_key_in,
    input  wire logic                      measuring_in,
    input  wire logic                      trig_wait_in,
    input  wire logic                      filter_settled_in,
    input  wire logic                      filter_enabled_in,
    input  wire logic                      idle_in,
    input  wire logic                      reading_done_in,
    input  wire logic                      over_range_in,
    input  wire logic                      low_limit_one_in,
    input  wire logic                      high_limit_one_in,
    input  wire logic                      low_limit_two_in,
    input  wire logic                      high_limit_two_in,
    input  wire logic                      hw_limit_in,
    input  wire logic                      buf_store_in,
    input  wire logic [`ISES_CNT_W-1:0]    buf_count_in,
    input  wire logic [`ISES_CNT_W-1:0]    buf_size_in,
    input  wire logic [`ISES_CNT_W-1:0]    notify_count_in,
    // Host command port
    input  wire logic                      std_read_in,
    input  wire logic                      opr_read_in,
    input  wire logic                      mea_read_in,
    input  wire logic                      clear_status_in,
    input  wire logic                      preset_in,
    input  wire logic                      std_en_wr_in,
    input  wire logic                      opr_en_wr_in,
    input  wire logic                      mea_en_wr_in,
    input  wire logic [15:0]               en_wdata_in,
    output logic      [7:0]                std_rdata_out,
    output logic      [15:0]               opr_rdata_out,
    output logic      [15:0]               mea_rdata_out,
    output logic      [7:0]                std_enable_out,
    output logic      [15:0]               opr_enable_out,
    output logic      [15:0]               mea_enable_out,
    output logic                           std_summary_out,
    output logic                           opr_summary_out,
    output logic                           mea_summary_out
);

    // ****************************************
    // Event sources
    // ****************************************
    ises_pkg::ises_byte_t std_q;
    ises_pkg::ises_byte_t std_d;
    ises_pkg::ises_word_t opr_q;
    ises_pkg::ises_word_t opr_d;
    ises_pkg::ises_word_t mea_q;
    ises_pkg::ises_word_t mea_d;
    ises_pkg::ises_byte_t std_en_q;
    ises_pkg::ises_word_t opr_en_q;
    ises_pkg::ises_word_t mea_en_q;
    ises_pkg::ises_byte_t std_set;
    ises_pkg::ises_word_t opr_set;
    ises_pkg::ises_word_t mea_set;
    logic                 pon_q;
    logic [`ISES_CNT_W-1:0] cnt_prev_q;

    wire logic opc_ev   = opc_query_in & ~ops_pending_in;
    wire logic bkm_ev   = err_scan_resume_in | err_data_lost_in;
    wire logic dev_ev   = bkm_ev | err_setup_mismatch_in | err_module_comm_in
                        | err_module_unsup_in;
    wire logic lim_any  = low_limit_one_in | high_limit_one_in | low_limit_two_in
                        | high_limit_two_in | hw_limit_in;

    // Threshold crossings of the stored reading count
    wire logic [`ISES_CNT_W-1:0] half_lvl  = buf_size_in >> 1;
    wire logic [`ISES_CNT_W-1:0] qtr_lvl   = buf_size_in >> 2;
    wire logic [`ISES_CNT_W+1:0] tq_wide   = ({2'b00, buf_size_in} * 18'h3) >> 2;
    wire logic [`ISES_CNT_W-1:0] tq_lvl    = tq_wide[`ISES_CNT_W-1:0];
    wire logic cnt_move   = buf_count_in != cnt_prev_q;
    wire logic hit_notify = cnt_move && buf_count_in == notify_count_in
                            && notify_count_in != '0;
    wire logic hit_half   = cnt_move && buf_count_in == half_lvl && half_lvl != '0;
    wire logic hit_full   = cnt_move && buf_count_in == buf_size_in && buf_size_in != '0;
    wire logic hit_qtr    = cnt_move && buf_count_in == qtr_lvl && qtr_lvl != '0;
    wire logic hit_tq     = cnt_move && buf_count_in == tq_lvl && tq_lvl != '0;
    wire logic buf_avail  = buf_count_in >= `ISES_BAV_MIN;
    wire logic buf_wrap   = buf_store_in && buf_count_in == buf_size_in
                            && buf_size_in != '0;

    // ****************************************
    // Set vectors
    // ****************************************
    always_comb begin
        std_set = `ISES_STD_RST;
        std_set[`ISES_STD_OPC_BIT] = opc_ev;
        std_set[`ISES_STD_QRY_BIT] = empty_queue_read_in;
        std_set[`ISES_STD_BKM_BIT] = bkm_ev | dev_ev;
        std_set[`ISES_STD_EXE_BIT] = exec_error_in;
        std_set[`ISES_STD_USR_BIT] = local_key_in;
        std_set[`ISES_STD_PON_BIT] = pon_q;
    end

    always_comb begin
        opr_set = `ISES_WIDE_RST;
        opr_set[`ISES_OPR_MEAS_BIT] = measuring_in;
        opr_set[`ISES_OPR_TRIG_BIT] = trig_wait_in;
        opr_set[`ISES_OPR_FILT_BIT] = filter_settled_in | ~filter_enabled_in;
        opr_set[`ISES_OPR_IDLE_BIT] = idle_in;
    end

    always_comb begin
        mea_set = `ISES_WIDE_RST;
        mea_set[`ISES_MEA_ROF_BIT] = over_range_in;
        mea_set[`ISES_MEA_LL1_BIT] = low_limit_one_in;
        mea_set[`ISES_MEA_HL1_BIT] = high_limit_one_in;
        mea_set[`ISES_MEA_LL2_BIT] = low_limit_two_in;
        mea_set[`ISES_MEA_HL2_BIT] = high_limit_two_in;
        mea_set[`ISES_MEA_RAV_BIT] = reading_done_in;
        mea_set[`ISES_MEA_BN_BIT]  = hit_notify;
        mea_set[`ISES_MEA_BAV_BIT] = buf_avail;
        mea_set[`ISES_MEA_BHF_BIT] = hit_half;
        mea_set[`ISES_MEA_BFL_BIT] = hit_full;
        mea_set[`ISES_MEA_BWR_BIT] = buf_wrap;
        mea_set[`ISES_MEA_HWL_BIT] = hw_limit_in;
        mea_set[`ISES_MEA_BQF_BIT] = hit_qtr;
        mea_set[`ISES_MEA_BTF_BIT] = hit_tq;
        mea_set[`ISES_MEA_ML_BIT]  = lim_any;
    end

    // ****************************************
    // Latching flags: set wins over read clear
    // ****************************************
    wire logic std_clr = std_read_in | clear_status_in;
    wire logic opr_clr = opr_read_in | clear_status_in;
    wire logic mea_clr = mea_read_in | clear_status_in;

    assign std_d = ((std_clr ? `ISES_STD_RST : std_q) | std_set)
                   & `ISES_STD_USED;
    assign opr_d = ((opr_clr ? `ISES_WIDE_RST : opr_q) | opr_set)
                   & `ISES_OPR_USED;
    assign mea_d = ((mea_clr ? `ISES_WIDE_RST : mea_q) | mea_set)
                   & `ISES_MEA_USED;

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            std_q <= `ISES_STD_RST;
            opr_q <= `ISES_WIDE_RST;
            mea_q <= `ISES_WIDE_RST;
        end else begin
            std_q <= std_d;
            opr_q <= opr_d;
            mea_q <= mea_d;
        end
    end

    // Power-on event pulses once after reset release
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pon_q      <= 1'b1;
            cnt_prev_q <= '0;
        end else begin
            pon_q      <= 1'b0;
            cnt_prev_q <= buf_count_in;
        end
    end

    // ****************************************
    // Enable registers
    // ****************************************
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            std_en_q <= `ISES_STD_RST;
            opr_en_q <= `ISES_WIDE_RST;
            mea_en_q <= `ISES_WIDE_RST;
        end else if (preset_in) begin
            std_en_q <= `ISES_STD_RST;
            opr_en_q <= `ISES_WIDE_RST;
            mea_en_q <= `ISES_WIDE_RST;
        end else begin
            if (std_en_wr_in) std_en_q <= en_wdata_in[`ISES_STD_W-1:0];
            if (opr_en_wr_in) opr_en_q <= en_wdata_in;
            if (mea_en_wr_in) mea_en_q <= en_wdata_in;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign std_rdata_out   = std_q;
    assign opr_rdata_out   = opr_q;
    assign mea_rdata_out   = mea_q;
    assign std_enable_out  = std_en_q;
    assign opr_enable_out  = opr_en_q;
    assign mea_enable_out  = mea_en_q;
    assign std_summary_out = |(std_q & std_en_q);
    assign opr_summary_out = |(opr_q & opr_en_q);
    assign mea_summary_out = |(mea_q & mea_en_q);

    // ****************************************
    // Assertions
    // ****************************************
    property p_opc_cause;
        @(posedge clock_in) disable iff (!nrst_in)
        $rose(std_q[`ISES_STD_OPC_BIT]) |-> $past(opc_query_in) && !$past(ops_pending_in);
    endproperty
    a_opc_cause: assert property (p_opc_cause) else $error("opc set without cause");

    property p_qry_set;
        @(posedge clock_in) disable iff (!nrst_in)
        empty_queue_read_in |=> std_q[`ISES_STD_QRY_BIT];
    endproperty
    a_qry_set: assert property (p_qry_set) else $error("query error not set");

    property p_dev_set;
        @(posedge clock_in) disable iff (!nrst_in)
        (err_module_comm_in || err_data_lost_in) |=> std_q[`ISES_STD_BKM_BIT];
    endproperty
    a_dev_set: assert property (p_dev_set) else $error("error bit 3 not set");

    property p_filt;
        @(posedge clock_in) disable iff (!nrst_in)
        !filter_enabled_in |=> opr_q[`ISES_OPR_FILT_BIT];
    endproperty
    a_filt: assert property (p_filt) else $error("filter bit not set");

    property p_latch;
        @(posedge clock_in) disable iff (!nrst_in)
        mea_q[`ISES_MEA_ROF_BIT] && !mea_read_in && !clear_status_in
            |=> mea_q[`ISES_MEA_ROF_BIT];
    endproperty
    a_latch: assert property (p_latch) else $error("flag dropped");

    property p_rdclr;
        @(posedge clock_in) disable iff (!nrst_in)
        opr_read_in && opr_set == '0 |=> opr_q == '0;
    endproperty
    a_rdclr: assert property (p_rdclr) else $error("read did not clear");

    property p_summary;
        @(posedge clock_in) disable iff (!nrst_in)
        mea_q[`ISES_MEA_ROF_BIT] && mea_en_q[`ISES_MEA_ROF_BIT]
            && !mea_read_in && !clear_status_in && !mea_en_wr_in && !preset_in
            |=> mea_summary_out;
    endproperty
    a_summary: assert property (p_summary) else $error("summary wrong");

    property p_preset;
        @(posedge clock_in) disable iff (!nrst_in)
        preset_in |=> opr_en_q == '0 && mea_en_q == '0 && std_en_q == '0;
    endproperty
    a_preset: assert property (p_preset) else $error("preset left enables");

    property p_unused;
        @(posedge clock_in) disable iff (!nrst_in)
        (opr_q & ~`ISES_OPR_USED) == '0 && (mea_q & ~`ISES_MEA_USED) == '0
            && (std_q & ~`ISES_STD_USED) == '0;
    endproperty
    a_unused: assert property (p_unused) else $error("unused bit set");

    property p_ml;
        @(posedge clock_in) disable iff (!nrst_in)
        hw_limit_in |=> mea_q[`ISES_MEA_ML_BIT] && mea_q[`ISES_MEA_HWL_BIT];
    endproperty
    a_ml: assert property (p_ml) else $error("limit flags not set");

    property p_bkm_set;
        @(posedge clock_in) disable iff (!nrst_in)
        err_scan_resume_in |=> std_q[`ISES_STD_BKM_BIT];
    endproperty
    a_bkm_set: assert property (p_bkm_set) else $error("backed memory bit not set");

    property p_exe_set;
        @(posedge clock_in) disable iff (!nrst_in)
        exec_error_in |=> std_q[`ISES_STD_EXE_BIT];
    endproperty
    a_exe_set: assert property (p_exe_set) else $error("execution error not set");

    property p_usr_set;
        @(posedge clock_in) disable iff (!nrst_in)
        local_key_in |=> std_q[`ISES_STD_USR_BIT];
    endproperty
    a_usr_set: assert property (p_usr_set) else $error("user request not set");

    property p_meas_set;
        @(posedge clock_in) disable iff (!nrst_in)
        measuring_in |=> opr_q[`ISES_OPR_MEAS_BIT];
    endproperty
    a_meas_set: assert property (p_meas_set) else $error("measuring bit not set");

    property p_idle_set;
        @(posedge clock_in) disable iff (!nrst_in)
        idle_in |=> opr_q[`ISES_OPR_IDLE_BIT];
    endproperty
    a_idle_set: assert property (p_idle_set) else $error("idle bit not set");

    property p_rof_set;
        @(posedge clock_in) disable iff (!nrst_in)
        over_range_in |=> mea_q[`ISES_MEA_ROF_BIT];
    endproperty
    a_rof_set: assert property (p_rof_set) else $error("overflow bit not set");

    property p_rav_set;
        @(posedge clock_in) disable iff (!nrst_in)
        reading_done_in |=> mea_q[`ISES_MEA_RAV_BIT];
    endproperty
    a_rav_set: assert property (p_rav_set) else $error("reading bit not set");

    property p_full_set;
        @(posedge clock_in) disable iff (!nrst_in)
        $changed(buf_count_in) && buf_count_in == buf_size_in && buf_size_in != '0
            |=> mea_q[`ISES_MEA_BFL_BIT];
    endproperty
    a_full_set: assert property (p_full_set) else $error("full bit not set");

    property p_en_keep;
        @(posedge clock_in) disable iff (!nrst_in)
        clear_status_in && !preset_in && !std_en_wr_in && !opr_en_wr_in && !mea_en_wr_in
            |=> $stable(std_en_q) && $stable(opr_en_q) && $stable(mea_en_q);
    endproperty
    a_en_keep: assert property (p_en_keep) else $error("clear status changed enables");

endmodule : ises_regs

// >>> ises_cfg.svh
// Bit positions, widths and reset values of the status event flag registers
`ifndef ISES_CFG_SVH
`define ISES_CFG_SVH

`define ISES_STD_W          8
`define ISES_OPR_W          16
`define ISES_MEA_W          16
`define ISES_STD_RST        8'h00
`define ISES_WIDE_RST       16'h0000

// Standard event bit positions
`define ISES_STD_OPC_BIT    0
`define ISES_STD_QRY_BIT    2
`define ISES_STD_BKM_BIT    3
`define ISES_STD_EXE_BIT    4
`define ISES_STD_DEV_BIT    3
`define ISES_STD_USR_BIT    6
`define ISES_STD_PON_BIT    7
`define ISES_STD_USED       8'hDD

// Operation event bit positions
`define ISES_OPR_MEAS_BIT   4
`define ISES_OPR_TRIG_BIT   5
`define ISES_OPR_FILT_BIT   8
`define ISES_OPR_IDLE_BIT   10
`define ISES_OPR_USED       16'h0530

// Measurement event bit positions
`define ISES_MEA_ROF_BIT    0
`define ISES_MEA_LL1_BIT    1
`define ISES_MEA_HL1_BIT    2
`define ISES_MEA_LL2_BIT    3
`define ISES_MEA_HL2_BIT    4
`define ISES_MEA_RAV_BIT    5
`define ISES_MEA_BN_BIT     6
`define ISES_MEA_BAV_BIT    7
`define ISES_MEA_BHF_BIT    8
`define ISES_MEA_BFL_BIT    9
`define ISES_MEA_BWR_BIT    10
`define ISES_MEA_HWL_BIT    11
`define ISES_MEA_BQF_BIT    12
`define ISES_MEA_BTF_BIT    13
`define ISES_MEA_ML_BIT     14
`define ISES_MEA_USED       16'h7FFF

// Buffer count width and least reading count for buffer-available
`define ISES_CNT_W          16
`define ISES_BAV_MIN        16'h0002

`endif

// >>> ises_pkg.sv
// Types shared by the status event flag register bank
package ises_pkg;
    typedef logic [15:0] ises_word_t;
    typedef logic [7:0]  ises_byte_t;
endpackage : ises_pkg

// >>> ises_host.sv
// Host controller model issuing register reads, enable writes and status commands
module ises_host (
    input  wire logic        clock_in,
    input  wire logic [7:0]  std_rdata_in,
    input  wire logic [15:0] opr_rdata_in,
    input  wire logic [15:0] mea_rdata_in,
    output logic             std_read_out,
    output logic             opr_read_out,
    output logic             mea_read_out,
    output logic             clear_status_out,
    output logic             preset_out,
    output logic             std_en_wr_out,
    output logic             opr_en_wr_out,
    output logic             mea_en_wr_out,
    output logic [15:0]      en_wdata_out
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        {std_read_out, opr_read_out, mea_read_out, clear_status_out, preset_out} = 5'h00;
        {std_en_wr_out, opr_en_wr_out, mea_en_wr_out} = 3'h0;
        en_wdata_out = 16'h0000;
    end

    // ****************************************
    // Host transfers, one strobe cycle each
    // ****************************************
    task automatic read_reg(input int sel, output ises_pkg::ises_word_t data);
        @(posedge clock_in);
        std_read_out <= (sel == 0);
        opr_read_out <= (sel == 1);
        mea_read_out <= (sel == 2);
        #1;
        // Value seen in the strobe cycle, cleared at the closing edge
        data = (sel == 0) ? {8'h00, std_rdata_in} : (sel == 1) ? opr_rdata_in : mea_rdata_in;
        @(posedge clock_in);
        std_read_out <= 1'b0;
        opr_read_out <= 1'b0;
        mea_read_out <= 1'b0;
    endtask : read_reg

    task automatic write_en(input int sel, input ises_pkg::ises_word_t data);
        @(posedge clock_in);
        std_en_wr_out <= (sel == 0);
        opr_en_wr_out <= (sel == 1);
        mea_en_wr_out <= (sel == 2);
        en_wdata_out  <= data;
        @(posedge clock_in);
        {std_en_wr_out, opr_en_wr_out, mea_en_wr_out} <= 3'h0;
    endtask : write_en

    task automatic command(input int sel);
        @(posedge clock_in);
        clear_status_out <= (sel == 0);
        preset_out       <= (sel == 1);
        @(posedge clock_in);
        clear_status_out <= 1'b0;
        preset_out       <= 1'b0;
    endtask : command
endmodule : ises_host

// >>> test_instrument_status_event_registers.sv
// Self-checking bench for the status event flag register bank
`include "ises_cfg.svh"
module test_instrument_status_event_registers;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock_in = 1'b0;
    logic nrst_in  = 1'b0;
    logic [20:0] ev = 21'h000000;
    logic ops_pending = 1'b0;
    logic filter_en = 1'b1;
    logic [`ISES_CNT_W-1:0] buf_count = 16'h0000, buf_size = 16'h0008, notify = 16'h0006;
    logic std_rd, opr_rd, mea_rd, clr, pre, std_wr, opr_wr, mea_wr;
    logic [15:0] wdata, opr_rdata, mea_rdata, opr_en, mea_en;
    logic [7:0] std_rdata, std_en;
    logic std_sum, opr_sum, mea_sum;
    int errors = 0;
    int check_count = 0;

    always #12.5 clock_in = ~clock_in;

    ises_regs i_dut (.clock_in(clock_in), .nrst_in(nrst_in), .opc_query_in(ev[0]),
        .ops_pending_in(ops_pending), .empty_queue_read_in(ev[1]), .err_scan_resume_in(ev[2]),
        .err_data_lost_in(ev[3]), .err_setup_mismatch_in(ev[4]), .err_module_comm_in(ev[5]),
        .err_module_unsup_in(ev[6]), .exec_error_in(ev[7]), .local_key_in(ev[8]),
        .measuring_in(ev[9]), .trig_wait_in(ev[10]), .filter_settled_in(ev[11]),
        .filter_enabled_in(filter_en), .idle_in(ev[12]), .reading_done_in(ev[13]),
        .over_range_in(ev[14]), .low_limit_one_in(ev[15]), .high_limit_one_in(ev[16]),
        .low_limit_two_in(ev[17]), .high_limit_two_in(ev[18]), .hw_limit_in(ev[19]),
        .buf_store_in(ev[20]), .buf_count_in(buf_count), .buf_size_in(buf_size),
        .notify_count_in(notify), .std_read_in(std_rd), .opr_read_in(opr_rd),
        .mea_read_in(mea_rd), .clear_status_in(clr), .preset_in(pre), .std_en_wr_in(std_wr),
        .opr_en_wr_in(opr_wr), .mea_en_wr_in(mea_wr), .en_wdata_in(wdata),
        .std_rdata_out(std_rdata), .opr_rdata_out(opr_rdata), .mea_rdata_out(mea_rdata),
        .std_enable_out(std_en), .opr_enable_out(opr_en), .mea_enable_out(mea_en),
        .std_summary_out(std_sum), .opr_summary_out(opr_sum), .mea_summary_out(mea_sum));

    ises_host i_host (.clock_in(clock_in), .std_rdata_in(std_rdata), .opr_rdata_in(opr_rdata),
        .mea_rdata_in(mea_rdata), .std_read_out(std_rd), .opr_read_out(opr_rd),
        .mea_read_out(mea_rd), .clear_status_out(clr), .preset_out(pre),
        .std_en_wr_out(std_wr), .opr_en_wr_out(opr_wr), .mea_en_wr_out(mea_wr),
        .en_wdata_out(wdata));

    // ****************************************
    // Shared helpers
    // ****************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic rd(input int sel, input logic [15:0] exp);
        ises_pkg::ises_word_t d;
        i_host.read_reg(sel, d);
        chk(d, exp);
    endtask : rd

    // Pulse one condition for a cycle, then read the register afterwards
    task automatic pr(input int idx, input int sel, input logic [15:0] exp);
        @(posedge clock_in);
        ev[idx] <= 1'b1;
        @(posedge clock_in);
        ev[idx] <= 1'b0;
        rd(sel, exp);
    endtask : pr

    task automatic final_report();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : final_report

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        chk({8'h00, std_en}, 16'h0000);
        chk(opr_en, 16'h0000);
        chk(mea_en, 16'h0000);
        rd(0, 16'h0080);
        rd(0, 16'h0000);
        rd(1, 16'h0000);
        rd(2, 16'h0000);
        $display("test reset done");
    endtask : t_reset

    task automatic t_std();
        ops_pending <= 1'b1;
        pr(0, 0, 16'h0000);
        ops_pending <= 1'b0;
        pr(0, 0, 16'h0001);
        pr(1, 0, 16'h0004);
        pr(2, 0, 16'h0008);
        pr(3, 0, 16'h0008);
        pr(4, 0, 16'h0008);
        pr(5, 0, 16'h0008);
        pr(6, 0, 16'h0008);
        pr(7, 0, 16'h0010);
        pr(8, 0, 16'h0040);
        $display("test standard events done");
    endtask : t_std

    task automatic t_opr_mea();
        pr(9, 1, 16'h0010);
        pr(10, 1, 16'h0020);
        pr(11, 1, 16'h0100);
        pr(12, 1, 16'h0400);
        @(posedge clock_in);
        filter_en <= 1'b0;
        @(posedge clock_in);
        filter_en <= 1'b1;
        rd(1, 16'h0100);
        pr(14, 2, 16'h0001);
        pr(15, 2, 16'h4002);
        pr(16, 2, 16'h4004);
        pr(17, 2, 16'h4008);
        pr(18, 2, 16'h4010);
        pr(19, 2, 16'h4800);
        pr(13, 2, 16'h0020);
        $display("test operation and measurement events done");
    endtask : t_opr_mea

    // Buffer of eight readings so that quarter levels are meaningful
    task automatic t_buffer();
        for (int k = 1; k <= 8; k++) begin
            @(posedge clock_in);
            ev[20] <= 1'b1;
            @(posedge clock_in);
            ev[20]    <= 1'b0;
            buf_count <= 16'(k);
        end
        rd(2, 16'h33C0);
        pr(20, 2, 16'h0480);
        buf_count <= 16'h0000;
        rd(2, 16'h0080);
        rd(2, 16'h0000);
        $display("test buffer levels done");
    endtask : t_buffer

    task automatic t_enables();
        i_host.write_en(0, 16'hFFFF);
        i_host.write_en(1, 16'hFFFF);
        i_host.write_en(2, 16'hFFFF);
        #1 chk({8'h00, std_en}, 16'h00FF);
        chk(opr_en, 16'hFFFF);
        chk(mea_en, 16'hFFFF);
        @(posedge clock_in);
        ev[12] <= 1'b1;
        ev[7]  <= 1'b1;
        @(posedge clock_in);
        ev[12] <= 1'b0;
        ev[7]  <= 1'b0;
        #1 chk({14'h0000, opr_sum, std_sum}, 16'h0003);
        rd(1, 16'h0400);
        rd(0, 16'h0010);
        #1 chk({14'h0000, opr_sum, std_sum}, 16'h0000);
        pr(8, 0, 16'h0040);
        #1 chk({15'h0000, std_sum}, 16'h0000);
        @(posedge clock_in);
        ev[14] <= 1'b1;
        @(posedge clock_in);
        ev[14] <= 1'b0;
        #1 chk({15'h0000, mea_sum}, 16'h0001);
        i_host.write_en(2, 16'h0000);
        #1 chk({15'h0000, mea_sum}, 16'h0000);
        i_host.write_en(2, 16'h0001);
        #1 chk({15'h0000, mea_sum}, 16'h0001);
        i_host.command(0);
        #1 chk({15'h0000, mea_sum}, 16'h0000);
        chk(mea_en, 16'h0001);
        rd(2, 16'h0000);
        i_host.command(1);
        #1 chk({8'h00, std_en}, 16'h0000);
        chk(opr_en, 16'h0000);
        chk(mea_en, 16'h0000);
        $display("test enables and summaries done");
    endtask : t_enables

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        repeat (6) @(posedge clock_in);
        nrst_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        t_reset();
        t_std();
        t_opr_mea();
        t_buffer();
        t_enables();
        final_report();
    end

    initial begin
        for (int i = 0; i < 20000; i++) @(posedge clock_in);
        errors++;
        final_report();
    end
endmodule : test_instrument_status_event_registers
